// *** design/port0_gpio.sv ***
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

`include "gpio_port_regs.svh"

module port0_gpio #(
    parameter int WIDTH = `REG_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // wishbone classic slave
    input wire gpio_port_pkg::wb_req_t wbReq,
    output logic wbAck,
    output logic [`WB_DAT_W-1:0] wbRdDat,
    // port pins
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut,
    output logic [WIDTH-1:0] pinOe,
    output logic [WIDTH-1:0] pinPullup,
    // interrupt request
    output logic irqReq
);

    import gpio_port_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    bus_state_t busState_q;
    bus_state_t busState_d;
    logic [`WB_DAT_W-1:0] rdDat_q;
    logic [`WB_DAT_W-1:0] rdDat_d;
    port_cfg_t cfg_q;

    logic [15:0] wordIdx;
    logic busReq;
    logic lane0;
    logic wrCommit;
    logic [WIDTH-1:0] wrByte;

    logic hitLevels;
    logic hitDrive;
    logic hitDriverOn;
    logic hitPullup;
    logic hitMask;
    logic hitEdge;
    logic hitPending;

    logic wrDrive;
    logic wrDriverOn;
    logic wrPullup;
    logic wrMask;
    logic wrEdge;
    logic wrPending;

    logic [WIDTH-1:0] pinLevelBits;
    logic [WIDTH-1:0] edgeHit;
    logic [WIDTH-1:0] irqPendingBits;
    logic [WIDTH-1:0] clrBits;
    logic [WIDTH-1:0] rdByte;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic idxHit(
        input logic [15:0] idx,
        input logic [15:0] target
    );
        idxHit = (idx == target);
    endfunction

    function automatic logic [WIDTH-1:0] selIf(
        input logic hit,
        input logic [WIDTH-1:0] val
    );
        selIf = hit ? val : '0;
    endfunction

    // ****************************************************************
    // address decode
    // ****************************************************************
    assign wordIdx = wbReq.adr[`IDX_MSB:`IDX_LSB];
    assign busReq = wbReq.cyc & wbReq.stb;
    assign lane0 = wbReq.sel[0];
    assign wrByte = wbReq.dat[WIDTH-1:0];

    assign hitLevels = idxHit(wordIdx, `PIN_LEVELS_IDX);
    assign hitDrive = idxHit(wordIdx, `DRIVE_LEVELS_IDX);
    assign hitDriverOn = idxHit(wordIdx, `DRIVER_ON_IDX);
    assign hitPullup = idxHit(wordIdx, `PULLUP_ON_IDX);
    assign hitMask = idxHit(wordIdx, `IRQ_MASK_IDX);
    assign hitEdge = idxHit(wordIdx, `IRQ_EDGE_IDX);
    assign hitPending = idxHit(wordIdx, `IRQ_PENDING_IDX);

    // ****************************************************************
    // bus handshake: ack one cycle after the request is seen
    // ****************************************************************
    always_comb begin
        busState_d = busState_q;
        case (busState_q)
            BUS_IDLE: begin
                if (busReq) begin
                    busState_d = BUS_ACK;
                end
            end
            BUS_ACK: begin
                busState_d = BUS_IDLE;
            end
            default: begin
                busState_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busState_q <= BUS_IDLE;
        end else begin
            busState_q <= busState_d;
        end
    end

    assign wbAck = (busState_q == BUS_ACK) & busReq;

    // writes land on the ack edge only, through byte lane 0
    assign wrCommit = wbAck & wbReq.we & lane0;

    assign wrDrive = wrCommit & hitDrive;
    assign wrDriverOn = wrCommit & hitDriverOn;
    assign wrPullup = wrCommit & hitPullup;
    assign wrMask = wrCommit & hitMask;
    assign wrEdge = wrCommit & hitEdge;
    assign wrPending = wrCommit & hitPending;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q.driveLevelBits <= `DRIVE_LEVELS_RST;
        end else if (wrDrive) begin
            cfg_q.driveLevelBits <= wrByte;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q.driverOnBits <= `DRIVER_ON_RST;
        end else if (wrDriverOn) begin
            cfg_q.driverOnBits <= wrByte;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q.pullupOnBits <= `PULLUP_ON_RST;
        end else if (wrPullup) begin
            cfg_q.pullupOnBits <= wrByte;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q.irqAllowBits <= `IRQ_MASK_RST;
        end else if (wrMask) begin
            cfg_q.irqAllowBits <= wrByte;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q.irqEdgeBits <= `IRQ_EDGE_RST;
        end else if (wrEdge) begin
            cfg_q.irqEdgeBits <= wrByte;
        end
    end

    // ****************************************************************
    // pin sampling and edge detection
    // ****************************************************************
    gpio_edge_sense #(
        .WIDTH(WIDTH)
    ) u_edge (
        .refClk(ref_clk),
        .arst_n(arst_n),
        .pinIn(pinIn),
        .fallingSel(cfg_q.irqEdgeBits),
        .level(pinLevelBits),
        .edgeHit(edgeHit)
    );

    // ****************************************************************
    // interrupt flags and request
    // ****************************************************************
    // a one written clears, a zero leaves the flag alone
    assign clrBits = wrPending ? wrByte : '0;

    gpio_irq_flags #(
        .WIDTH(WIDTH),
        .RST_VAL(`IRQ_PENDING_RST)
    ) u_flags (
        .refClk(ref_clk),
        .arst_n(arst_n),
        .setBits(edgeHit),
        .clrBits(clrBits),
        .allowBits(cfg_q.irqAllowBits),
        .flags(irqPendingBits),
        .irq(irqReq)
    );

    // ****************************************************************
    // read path
    // ****************************************************************
    // unmapped words and index 0x5204 read as zero
    assign rdByte = selIf(hitLevels, pinLevelBits)
        | selIf(hitDrive, cfg_q.driveLevelBits)
        | selIf(hitDriverOn, cfg_q.driverOnBits)
        | selIf(hitPullup, cfg_q.pullupOnBits)
        | selIf(hitMask, cfg_q.irqAllowBits)
        | selIf(hitEdge, cfg_q.irqEdgeBits)
        | selIf(hitPending, irqPendingBits);

    assign rdDat_d = (busState_q == BUS_IDLE) && busReq && !wbReq.we ?
        {{(`WB_DAT_W-WIDTH){1'b0}}, rdByte} : rdDat_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdDat_q <= 32'h0000_0000;
        end else begin
            rdDat_q <= rdDat_d;
        end
    end

    assign wbRdDat = rdDat_q;

    // ****************************************************************
    // pin drivers
    // ****************************************************************
    assign pinOut = cfg_q.driveLevelBits;
    assign pinOe = cfg_q.driverOnBits;
    assign pinPullup = cfg_q.pullupOnBits;

endmodule

`default_nettype wire

// *** inc/gpio_port_regs.svh ***
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// ****************************************************************
// register indices; byte address is four times the index
// ****************************************************************
`define PIN_LEVELS_IDX 16'h5200
`define DRIVE_LEVELS_IDX 16'h5201
`define DRIVER_ON_IDX 16'h5202
`define PULLUP_ON_IDX 16'h5203
`define IRQ_MASK_IDX 16'h5205
`define IRQ_EDGE_IDX 16'h5206
`define IRQ_PENDING_IDX 16'h5207

// ****************************************************************
// reset values
// ****************************************************************
`define DRIVE_LEVELS_RST 8'h00
`define DRIVER_ON_RST 8'h00
`define PULLUP_ON_RST 8'hff
`define IRQ_MASK_RST 8'h00
`define IRQ_EDGE_RST 8'h00
`define IRQ_PENDING_RST 8'h00

// ****************************************************************
// bus layout
// ****************************************************************
`define WB_ADR_W 18
`define WB_DAT_W 32
`define WB_SEL_W 4
`define REG_W 8
`define IDX_LSB 2
`define IDX_MSB 17

`endif

// *** inc/gpio_port_pkg.sv ***
`include "gpio_port_regs.svh"

package gpio_port_pkg;

    // wishbone classic request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [`WB_ADR_W-1:0] adr;
        logic [`WB_SEL_W-1:0] sel;
        logic [`WB_DAT_W-1:0] dat;
    } wb_req_t;

    // software-held port configuration
    typedef struct packed {
        logic [`REG_W-1:0] driveLevelBits;
        logic [`REG_W-1:0] driverOnBits;
        logic [`REG_W-1:0] pullupOnBits;
        logic [`REG_W-1:0] irqAllowBits;
        logic [`REG_W-1:0] irqEdgeBits;
    } port_cfg_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

endpackage

// *** design/gpio_edge_sense.sv ***
`timescale 1ns/10ps
`default_nettype none

module gpio_edge_sense #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic refClk,
    input wire logic arst_n,
    // pins and edge choice
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] fallingSel,
    // synchronised level and edge pulses
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] edgeHit
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
    logic [2:0] fill_q;
    logic armed;

    // ****************************************************************
    // two-flop synchroniser, then one history stage
    // ****************************************************************
    always_ff @(posedge refClk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
            fill_q <= '0;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
            fill_q <= {fill_q[1:0], 1'b1};
        end
    end

    // no edges until history holds real pin samples, else pulled-up pins fake one
    assign armed = fill_q[2];

    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
    assign level = sync_q;
    assign edgeHit = {WIDTH{armed}} & ((fallingSel & fall) | (~fallingSel & rise));

endmodule

`default_nettype wire

// *** design/gpio_irq_flags.sv ***
`timescale 1ns/10ps
`default_nettype none

module gpio_irq_flags #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic refClk,
    input wire logic arst_n,
    // events, software clear and interrupt enable mask
    input wire logic [WIDTH-1:0] setBits,
    input wire logic [WIDTH-1:0] clrBits,
    input wire logic [WIDTH-1:0] allowBits,
    // flags and request
    output logic [WIDTH-1:0] flags,
    output logic irq
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    // set wins over a clear in the same cycle
    assign flags_d = setBits | (flags_q & ~clrBits);

    always_ff @(posedge refClk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= RST_VAL;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;
    assign irq = |(flags_q & allowBits);

endmodule

`default_nettype wire

// *** bench/port0_gpio_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_regs.svh"
module port0_gpio_asserts #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // bus
    input wire gpio_port_pkg::wb_req_t wbReq,
    input wire logic wbAck,
    input wire logic [`WB_DAT_W-1:0] wbRdDat,
    // pins and request
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] pinOut,
    input wire logic [WIDTH-1:0] pinOe,
    input wire logic [WIDTH-1:0] pinPullup,
    input wire logic irqReq
);
    import gpio_port_pkg::*;
    wire logic [15:0] idx;
    wire logic wrAck;
    assign idx = wbReq.adr[`IDX_MSB:`IDX_LSB];
    assign wrAck = wbAck && wbReq.we && wbReq.sel[0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_pin_rd;
        wbAck && !wbReq.we && idx == `PIN_LEVELS_IDX && $past(pinIn, 2) == $past(pinIn, 3)
            && $past(pinIn, 3) == $past(pinIn, 4) |-> wbRdDat == 32'($past(pinIn, 3));
    endproperty
    a_pin_rd: assert property (p_pin_rd) else $error("pin level read wrong");
    property p_out_wr;
        wrAck && idx == `DRIVE_LEVELS_IDX |=> pinOut == $past(wbReq.dat[WIDTH-1:0]);
    endproperty
    a_out_wr: assert property (p_out_wr) else $error("pinOut not updated");
    property p_oe_wr;
        wrAck && idx == `DRIVER_ON_IDX |=> pinOe == $past(wbReq.dat[WIDTH-1:0]);
    endproperty
    a_oe_wr: assert property (p_oe_wr) else $error("pinOe not updated");
    property p_pu_wr;
        wrAck && idx == `PULLUP_ON_IDX |=> pinPullup == $past(wbReq.dat[WIDTH-1:0]);
    endproperty
    a_pu_wr: assert property (p_pu_wr) else $error("pinPullup not updated");
    property p_mask_off;
        wrAck && idx == `IRQ_MASK_IDX && wbReq.dat[7:0] == 8'h00 |=> !irqReq [*2];
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq with mask off");
    property p_irq_rise;
        $rose(irqReq) |-> $past(pinIn, 3) != $past(pinIn, 4) || $past(wrAck);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose with no cause");
    property p_clear;
        wrAck && idx == `IRQ_PENDING_IDX && wbReq.dat[7:0] == 8'hff && $stable(pinIn)
            && $past(pinIn, 2) == pinIn && $past(pinIn, 3) == pinIn |=> !irqReq;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");
    property p_irq_fall;
        $fell(irqReq) |-> $past(wrAck);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
endmodule
`default_nettype wire

// *** bench/pin_board.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_board #(
    parameter int WIDTH = 8
) (
    // clock
    input wire logic ref_clk,
    // device side
    input wire logic [WIDTH-1:0] pinOut,
    input wire logic [WIDTH-1:0] pinOe,
    input wire logic [WIDTH-1:0] pinPullup,
    // board side
    input wire logic [WIDTH-1:0] brdVal,
    input wire logic [WIDTH-1:0] brdEn,
    // resolved levels
    output logic [WIDTH-1:0] pinIn
);
    logic [WIDTH-1:0] drv;
    logic [WIDTH-1:0] val;
    logic [WIDTH-1:0] holdQ = '0;
    assign drv = pinOe | brdEn;
    // device driver wins over the board
    assign val = (pinOe & pinOut) | (~pinOe & brdVal);
    // undriven: pull-up, else inverse of last driven level
    assign pinIn = (drv & val) | (~drv & (pinPullup | ~holdQ));
    always_ff @(posedge ref_clk) begin
        holdQ <= (drv & val) | (~drv & holdQ);
    end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_regs.svh"
module tb_top;
    import gpio_port_pkg::*;
    localparam logic [7:0] RSTV [8] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    wb_req_t wbReq = '0;
    logic wbAck;
    logic irqReq;
    logic [31:0] wbRdDat;
    logic [7:0] pinIn, pinOut, pinOe, pinPullup;
    logic [7:0] brdVal = 8'h00;
    logic [7:0] brdEn = 8'hff;
    int fails = 0;
    int numChecks = 0;
    always #5 ref_clk = ~ref_clk;
    port0_gpio i_port0_gpio (.ref_clk(ref_clk), .arst_n(arst_n), .wbReq(wbReq), .wbAck(wbAck),
        .wbRdDat(wbRdDat), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullup(pinPullup), .irqReq(irqReq));
    pin_board i_pin_board (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullup(pinPullup), .brdVal(brdVal), .brdEn(brdEn), .pinIn(pinIn));
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        numChecks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [15:0] idx, input logic [3:0] sel,
        input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        wbReq <= '{1'b1, 1'b1, we, {idx, 2'b00}, sel, {24'h00_0000, d}};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("BAD wbAck exp 1 got 0");
        end
        q = wbRdDat[7:0];
        wbReq.cyc <= 1'b0;
        wbReq.stb <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, 4'hf, d, q);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, idx, 4'hf, 8'h00, q);
        chk($sformatf("reg %h", idx), e, q);
    endtask
    task automatic brd(input logic [7:0] en, input logic [7:0] v);
        @(posedge ref_clk);
        brdEn <= en;
        brdVal <= v;
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic irq(input logic e);
        @(posedge ref_clk);
        chk("irqReq", {7'h00, e}, {7'h00, irqReq});
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        logic [7:0] q;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        chk("pinOut", 8'h00, pinOut);
        chk("pinOe", 8'h00, pinOe);
        chk("pinPullup", 8'hff, pinPullup);
        for (int i = 0; i < 8; i++) begin
            rd(`PIN_LEVELS_IDX + 16'(i), RSTV[i]);
        end
        irq(1'b0);
        $display("test reset done");
        wr(`DRIVE_LEVELS_IDX, 8'ha5);
        wr(`DRIVER_ON_IDX, 8'h5a);
        wr(`PULLUP_ON_IDX, 8'h3c);
        wb(1'b1, `DRIVE_LEVELS_IDX, 4'he, 8'h00, q);
        wr(16'h5204, 8'h77);
        rd(16'h5204, 8'h00);
        rd(`DRIVE_LEVELS_IDX, 8'ha5);
        chk("pinOut", 8'ha5, pinOut);
        chk("pinOe", 8'h5a, pinOe);
        chk("pinPullup", 8'h3c, pinPullup);
        $display("test registers done");
        wr(`DRIVE_LEVELS_IDX, 8'h0f);
        brd(8'ha5, 8'h30);
        rd(`PIN_LEVELS_IDX, 8'h2a);
        brd(8'h00, 8'h00);
        rd(`PIN_LEVELS_IDX, 8'haf);
        brd(8'hff, 8'h00);
        wr(`DRIVER_ON_IDX, 8'h00);
        $display("test pins done");
        wr(`IRQ_EDGE_IDX, 8'h0f);
        wr(`IRQ_PENDING_IDX, 8'hff);
        rd(`IRQ_PENDING_IDX, 8'h00);
        brd(8'hff, 8'hff);
        rd(`IRQ_PENDING_IDX, 8'hf0);
        irq(1'b0);
        wr(`IRQ_MASK_IDX, 8'h10);
        irq(1'b1);
        brd(8'hff, 8'h00);
        rd(`IRQ_PENDING_IDX, 8'hff);
        wr(`IRQ_PENDING_IDX, 8'h10);
        rd(`IRQ_PENDING_IDX, 8'hef);
        irq(1'b0);
        wr(`IRQ_MASK_IDX, 8'h01);
        irq(1'b1);
        wr(`IRQ_MASK_IDX, 8'h00);
        irq(1'b0);
        wr(`IRQ_PENDING_IDX, 8'hff);
        rd(`IRQ_PENDING_IDX, 8'h00);
        $display("test interrupts done");
        // mid-run reset with all pins left to pull-ups, so they sit high
        brd(8'h00, 8'h00);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rd(`IRQ_PENDING_IDX, 8'h00);
        rd(`IRQ_EDGE_IDX, 8'h00);
        rd(`PULLUP_ON_IDX, 8'hff);
        rd(`PIN_LEVELS_IDX, 8'hff);
        irq(1'b0);
        $display("test mid-run reset done");
        end_sim();
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        end_sim();
    end
endmodule
bind port0_gpio port0_gpio_asserts #(.WIDTH(WIDTH)) u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .wbReq(wbReq), .wbAck(wbAck), .wbRdDat(wbRdDat), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinPullup(pinPullup), .irqReq(irqReq));
`default_nettype wire
